// File: pin_ctl_pkg.sv
/*
  Constants for the per-pin control block: register offsets, field positions, reset values and trigger codes.
  Assumes a plain register port with 32-bit data and byte addresses.
*/
// How it works
// - trigger codes 000 rising, 001 falling, 010 both edges in bits 23:21.
// - code 011 detects high level, 100 low level; other codes detect nothing.
// - detect enable bit 20 low blocks pending flag and any request.
// - detect enable high sets the pending flag on each selected trigger.
// - forward mask bit 25 low suppresses delivery to the interrupt controller.
// - forward mask high delivers the request once the trigger is detected.
// - request raised only with detect enabled and forward mask set.
// - pad drive field bits 14:12 picks one of eight levels, resets to 1.
// - bit 11 strong pull-up, bit 9 weak pull-down, bit 8 medium pull-up.
// - bit 5 enables the pad Schmitt input, reset low.
// - function selector bits 3:0, code 0000 plain I/O, others alternate.
package pin_ctl_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned num_pins = 5;
  localparam logic [7:0] pin19_control_off = 8'h50;
  localparam logic [7:0] pin20_control_off = 8'h54;
  localparam logic [7:0] pin21_control_off = 8'h58;
  localparam logic [7:0] pin22_control_off = 8'h5c;
  localparam logic [7:0] pin23_control_off = 8'h60;
  localparam logic [7:0] pending_status_off = 8'h90;
  localparam logic [7:0] pin_level_off = 8'h94;
  localparam logic [7:0] out_data_off = 8'h98;
  // ----------------------------------------------------------------
  // control field positions and reset
  // ----------------------------------------------------------------
  localparam int unsigned fwd_mask_bit = 25;
  localparam int unsigned trig_hi = 23;
  localparam int unsigned trig_lo = 21;
  localparam int unsigned detect_en_bit = 20;
  localparam int unsigned drive_hi = 14;
  localparam int unsigned drive_lo = 12;
  localparam int unsigned pu_strong_bit = 11;
  localparam int unsigned pd_weak_bit = 9;
  localparam int unsigned pu_medium_bit = 8;
  localparam int unsigned in_en_bit = 7;
  localparam int unsigned out_en_bit = 6;
  localparam int unsigned schmitt_bit = 5;
  localparam int unsigned func_hi = 3;
  localparam logic [31:0] ctl_writable_mask = 32'h02f0_7bef;
  localparam logic [31:0] ctl_reset = 32'h0000_1000;
  // ----------------------------------------------------------------
  // trigger and function codes
  // ----------------------------------------------------------------
  localparam logic [2:0] trig_rise = 3'h0;
  localparam logic [2:0] trig_fall = 3'h1;
  localparam logic [2:0] trig_both = 3'h2;
  localparam logic [2:0] trig_high = 3'h3;
  localparam logic [2:0] trig_low = 3'h4;
  localparam logic [3:0] func_plain_io = 4'h0;
endpackage

// File: pin_sync.sv
/*
  Two-flop synchroniser for pad inputs.
  Assumes the input is asynchronous to sys_clk.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter int unsigned width = 5
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] stage1;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// File: trigger_detect.sv
/*
  Per-pin trigger detector: one-cycle hit for the selected edge, a hit held for as long as the selected level holds.
  Assumes a synchronised input level.
*/
`timescale 1ns/10ps
module trigger_detect (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic level_in,
  input wire logic [2:0] trigger_select,
  output logic hit
);
  import pin_ctl_pkg::*;
  logic prev_level;
  logic next_prev_level;
  always_comb begin
    next_prev_level = level_in;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_level <= 1'b0;
    end else begin
      prev_level <= next_prev_level;
    end
  end
  always_comb begin
    unique case (trigger_select)
      trig_rise: hit = level_in & ~prev_level;
      trig_fall: hit = ~level_in & prev_level;
      trig_both: hit = level_in ^ prev_level;
      trig_high: hit = level_in;
      trig_low: hit = ~level_in;
      default: hit = 1'b0;
    endcase
  end
endmodule

// File: pin_control_irq_detect.sv
/*
  Per-pin control registers with trigger detection, pending flags and masked interrupt requests.
  Assumes a plain register port on sys_clk and asynchronous pad inputs.
*/
// Local design decision: strobed register access.
`timescale 1ns/10ps
module pin_control_irq_detect #(
  parameter int unsigned pins = pin_ctl_pkg::num_pins
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic [pins-1:0] pad_in,
  input wire logic [pins-1:0] alt_out,
  input wire logic [pins-1:0] alt_oe,
  output logic [pins-1:0] pad_out,
  output logic [pins-1:0] pad_oe,
  output logic [pins-1:0] pad_in_en,
  output logic [pins*3-1:0] pad_drive_level,
  output logic [pins-1:0] pullup_strong_en,
  output logic [pins-1:0] pulldown_weak_en,
  output logic [pins-1:0] pullup_medium_en,
  output logic [pins-1:0] schmitt_input_en,
  output logic [pins*4-1:0] pin_function_select,
  output logic [pins-1:0] pin_in_to_alt,
  output logic [pins-1:0] irq_to_controller
);
  import pin_ctl_pkg::*;
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] ctl [pins];
  logic [31:0] next_ctl [pins];
  logic [pins-1:0] pending;
  logic [pins-1:0] next_pending;
  logic [pins-1:0] out_data;
  logic [pins-1:0] next_out_data;
  logic [31:0] next_rdata;
  logic [pins-1:0] level_sync;
  logic [pins-1:0] hit;
  logic [pins-1:0] gated_in;
  pin_sync #(.width(pins)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(pad_in),
    .sync_out(level_sync)
  );
  // ----------------------------------------------------------------
  // per-pin pad control and detection
  // ----------------------------------------------------------------
  for (genvar i = 0; i < pins; i++) begin : g_pin
    logic plain_io;
    assign plain_io = ctl[i][func_hi:0] == func_plain_io;
    // a disabled input buffer reads low so a floating pad can fire only the low-level trigger
    assign gated_in[i] = level_sync[i] & ctl[i][in_en_bit];
    trigger_detect u_det (
      .sys_clk(sys_clk),
      .rst(rst),
      .level_in(gated_in[i]),
      .trigger_select(ctl[i][trig_hi:trig_lo]),
      .hit(hit[i])
    );
    assign pad_out[i] = plain_io ? out_data[i] : alt_out[i];
    assign pad_oe[i] = ctl[i][out_en_bit] & (plain_io | alt_oe[i]);
    assign pad_in_en[i] = ctl[i][in_en_bit];
    assign pin_in_to_alt[i] = plain_io ? 1'b0 : gated_in[i];
    assign pad_drive_level[i*3 +: 3] = ctl[i][drive_hi:drive_lo];
    assign pullup_strong_en[i] = ctl[i][pu_strong_bit];
    assign pulldown_weak_en[i] = ctl[i][pd_weak_bit];
    assign pullup_medium_en[i] = ctl[i][pu_medium_bit];
    assign schmitt_input_en[i] = ctl[i][schmitt_bit];
    assign pin_function_select[i*4 +: 4] = ctl[i][func_hi:0];
    // request needs both enable and mask; pending alone never reaches the controller
    assign irq_to_controller[i] = pending[i] & ctl[i][detect_en_bit] & ctl[i][fwd_mask_bit];
  end
  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  function automatic logic [7:0] pin_offset(input int unsigned idx);
    unique case (idx)
      0: pin_offset = pin19_control_off;
      1: pin_offset = pin20_control_off;
      2: pin_offset = pin21_control_off;
      3: pin_offset = pin22_control_off;
      default: pin_offset = pin23_control_off;
    endcase
  endfunction
  always_comb begin
    next_out_data = out_data;
    next_pending = pending;
    next_rdata = 32'h0000_0000;
    for (int i = 0; i < pins; i++) begin
      next_ctl[i] = ctl[i];
      if (reg_write && reg_addr == pin_offset(i)) begin
        next_ctl[i] = reg_wdata & ctl_writable_mask;
      end
      if (reg_read && reg_addr == pin_offset(i)) begin
        next_rdata = ctl[i];
      end
      // write one to clear; a hit in the same cycle wins
      if (reg_write && reg_addr == pending_status_off && reg_wdata[i]) begin
        next_pending[i] = 1'b0;
      end
      if (ctl[i][detect_en_bit] && hit[i]) begin
        next_pending[i] = 1'b1;
      end
    end
    if (reg_write && reg_addr == out_data_off) begin
      next_out_data = reg_wdata[pins-1:0];
    end
    if (reg_read && reg_addr == pending_status_off) begin
      next_rdata = {{(32-pins){1'b0}}, pending};
    end
    if (reg_read && reg_addr == pin_level_off) begin
      next_rdata = {{(32-pins){1'b0}}, gated_in};
    end
    if (reg_read && reg_addr == out_data_off) begin
      next_rdata = {{(32-pins){1'b0}}, out_data};
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < pins; i++) begin
        ctl[i] <= ctl_reset;
      end
      pending <= '0;
      out_data <= '0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < pins; i++) begin
        ctl[i] <= next_ctl[i];
      end
      pending <= next_pending;
      out_data <= next_out_data;
      reg_rdata <= next_rdata;
    end
  end
endmodule

// File: pin_irq_sva.sv
/* checker for the pin control block ports
   sees only the top ports; bound from the bench */
`timescale 1ns/10ps
module pin_irq_sva #(
  parameter int unsigned pins = 5
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [pins*3-1:0] pad_drive_level,
  input wire logic [pins-1:0] pullup_strong_en,
  input wire logic [pins-1:0] pad_in_en,
  input wire logic [pins-1:0] schmitt_input_en,
  input wire logic [pins*4-1:0] pin_function_select,
  input wire logic [pins-1:0] irq_to_controller
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----
  // pin20 shadow of both request gates
  // ----
  logic fwd;
  logic det;
  wire wr20 = reg_write && reg_addr == 8'h54;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fwd <= 1'b0;
      det <= 1'b0;
    end else if (wr20) begin
      fwd <= reg_wdata[25];
      det <= reg_wdata[20];
    end
  end
  a_reserved_zero: assert property ($past(reg_read) |-> (reg_rdata & 32'hfd0f8410) == 32'h0)
    else $error("reserved bits read back set");
  a_drive_write: assert property (wr20 |=> pad_drive_level[5:3] == $past(reg_wdata[14:12]))
    else $error("drive level not taken");
  a_pullup_write: assert property (wr20 |=> pullup_strong_en[1] == $past(reg_wdata[11]))
    else $error("pull-up enable not taken");
  a_schmitt_write: assert property (wr20 |=> schmitt_input_en[1] == $past(reg_wdata[5]))
    else $error("schmitt enable not taken");
  a_func_write: assert property (wr20 |=> pin_function_select[7:4] == $past(reg_wdata[3:0]))
    else $error("function select not taken");
  a_inbuf_write: assert property (wr20 |=> pad_in_en[1] == $past(reg_wdata[7]))
    else $error("input buffer enable not taken");
  a_reset_state: assert property ($fell(rst) |-> pad_drive_level == {pins{3'h1}} && pad_in_en == '0)
    else $error("wrong state after reset");
  a_irq_gated: assert property (irq_to_controller[1] |-> fwd && det)
    else $error("request without both gates");
  a_mask_blocks: assert property (wr20 && !reg_wdata[25] |=> !irq_to_controller[1] ##1 (!irq_to_controller[1] || $past(wr20)))
    else $error("request while masked");
  a_detect_blocks: assert property (wr20 && !reg_wdata[20] |=> !irq_to_controller[1] ##1 (!irq_to_controller[1] || $past(wr20)))
    else $error("request while detect off");
endmodule

// File: pin_far_model.sv
/* far side: alternate peripheral drive and interrupt controller sink
   runs on the block's own clock */
`timescale 1ns/10ps
module pin_far_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] irq_to_controller,
  output logic [4:0] alt_out,
  output logic [4:0] alt_oe,
  output logic irq_seen
);
  // ----
  // drive changes every cycle so a stale value never looks valid
  // ----
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alt_out <= 5'h0;
      alt_oe <= 5'h0;
      irq_seen <= 1'b0;
    end else begin
      alt_out <= ~alt_out;
      alt_oe <= alt_oe + 5'h1;
      irq_seen <= irq_seen | (|irq_to_controller);
    end
  end
endmodule

// File: pin_control_irq_detect_bench.sv
/* bench for the pin control block
   needs the package, design, checker and far-side model */
`timescale 1ns/10ps
module pin_control_irq_detect_bench;
  import pin_ctl_pkg::*;
  // ----
  // signals and helpers
  // ----
  logic sys_clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, irq_seen;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, seed = 32'hb967, d, x;
  logic [4:0] pad_in = 5'h0, alt_out, alt_oe, pad_in_en, pullup_strong_en, pulldown_weak_en, pullup_medium_en;
  logic [4:0] schmitt_input_en, irq_to_controller;
  logic [4:0] pad_out, pad_oe, pin_in_to_alt;
  // plain-io output data written once, so pad_out shows a known pattern per pin
  localparam logic [4:0] out_val = 5'h0a;
  logic [14:0] pad_drive_level;
  logic [19:0] pin_function_select;
  int fails = 0, checked = 0, p;
  pin_control_irq_detect i_dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .pad_in,
    .alt_out, .alt_oe, .pad_out, .pad_oe, .pad_in_en, .pad_drive_level, .pullup_strong_en, .pulldown_weak_en,
    .pullup_medium_en, .schmitt_input_en, .pin_function_select, .pin_in_to_alt, .irq_to_controller);
  pin_far_model i_far (.sys_clk, .rst, .irq_to_controller, .alt_out, .alt_oe, .irq_seen);
  always #4 sys_clk = ~sys_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // level codes also fire on the start level, which is held while detect is on
  function automatic logic hit(input logic [2:0] c, input logic s, input logic e);
    case (c)
      trig_rise: return !s && e;
      trig_fall: return s && !e;
      trig_both: return s != e;
      trig_high: return s || e;
      default: return !s || !e;
    endcase
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic end_of_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(pin19_control_off + 8'(4 * i));
      check(d, ctl_reset);
    end
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10);
    check(d, 32'h0);
    wr(out_data_off, 32'hffff_ffea);
    rd(out_data_off);
    check(d, 32'(out_val));
    $display("reset and unmapped test done");
    repeat (20) begin
      seed = lfsr(seed);
      p = seed[10:8] % 5;
      // pads move off the clock edge; the two sync stages settle within the write and read below
      pad_in <= seed[20:16];
      wr(pin19_control_off + 8'(4 * p), seed);
      rd(pin19_control_off + 8'(4 * p));
      check(d, seed & ctl_writable_mask);
      check(32'(pad_drive_level[p*3 +: 3]), 32'(seed[14:12]));
      check(32'({pullup_strong_en[p], pulldown_weak_en[p], pullup_medium_en[p]}), 32'({seed[11], seed[9:8]}));
      check(32'(schmitt_input_en[p]), 32'(seed[5]));
      check(32'(pin_function_select[p*4 +: 4]), 32'(seed[3:0]));
      check(32'({pad_in_en[p], pad_oe[p]}), 32'({seed[7], seed[6] && (seed[3:0] == 4'h0 || alt_oe[p])}));
      x = 32'(seed[3:0] == 4'h0 ? out_val[p] : alt_out[p]);
      check(32'(pad_out[p]), x);
      check(32'(pin_in_to_alt[p]), 32'(seed[3:0] != 4'h0 && seed[7] && pad_in[p]));
    end
    $display("random field test done");
    // second reset in mid-run: everything the random test left behind must be gone
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(pin20_control_off);
    check(d, ctl_reset);
    rd(pending_status_off);
    check(d, 32'h0);
    check(32'({irq_seen, irq_to_controller}), 32'h0);
    $display("mid-run reset test done");
    for (int c = 0; c < 5; c++) begin
      for (int s = 0; s < 2; s++) begin
        wr(pin20_control_off, 32'h0200_0080 | (32'(c) << 21));
        // clear first, so a hit while detection is off would still show
        wr(pending_status_off, 32'h1f);
        pad_in[1] <= s[0];
        repeat (6) @(posedge sys_clk);
        rd(pending_status_off);
        check(32'({d[1], irq_to_controller[1]}), 32'h0);
        wr(pin20_control_off, 32'h0210_0080 | (32'(c) << 21));
        pad_in[1] <= !s[0];
        repeat (6) @(posedge sys_clk);
        x = 32'(hit(3'(c), s[0], !s[0]));
        rd(pending_status_off);
        check(32'(d[1]), x);
        check(32'(irq_to_controller[1]), x);
        rd(pin_level_off);
        check(d, 32'(!s[0]) << 1);
        wr(pin20_control_off, 32'h0010_0080 | (32'(c) << 21));
        #1 check(32'(irq_to_controller[1]), 32'h0);
        rd(pending_status_off);
        check(32'(d[1]), x);
      end
    end
    check(32'(irq_seen), 32'h1);
    $display("trigger test done");
    end_of_test();
  end
endmodule
bind pin_control_irq_detect pin_irq_sva #(.pins(pins)) i_sva (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_write,
  .reg_read, .reg_rdata, .pad_drive_level, .pullup_strong_en, .pad_in_en, .schmitt_input_en, .pin_function_select,
  .irq_to_controller);
